// ===== onoff_map.svh
// Register offsets, field positions, reset values and timing counts
// for the per-channel on/off and margin control block.
// Assumes inclusion by the design modules only.
`ifndef ONOFF_MAP_SVH
`define ONOFF_MAP_SVH

// Command codes on the serial management port
`define CMD_OPERATION       8'h01
`define CMD_ONOFF_CONFIG    8'h02
`define CMD_MFR_CONFIG      8'hD0
`define PAGE_GLOBAL         8'hFF

// Reset values
`define RST_OPERATION       8'h00
`define RST_ONOFF_CONFIG    8'h12
`define RST_MFR_CONFIG      16'h0080

// Operation command fields
`define OP_CTRL_HI          7
`define OP_CTRL_LO          6
`define OP_MARGIN_HI        5
`define OP_MARGIN_LO        4
`define OP_FAULT_HI         3
`define OP_FAULT_LO         2
`define OP_WR_MASK          8'hFC

// Gating configuration fields
`define CFG_CONTROLLED_ON   4
`define CFG_USE_BUS         3
`define CFG_USE_PIN         2
`define CFG_FAST_OFF        0
`define CFG_WR_MASK         8'h1D
`define CFG_RD_ONE          8'h02

// Manufacturer configuration fields
`define MFR_TRACK_EN        15
`define MFR_CASCADE_ON      14
`define MFR_RSVD_MASK       16'hFDFF

// Operation control codes
`define CTRL_OFF_NOW        2'b00
`define CTRL_SEQ_OFF        2'b01
`define CTRL_SEQ_ON         2'b10

// Margin codes
`define MARGIN_NOMINAL      2'b00
`define MARGIN_LOW          2'b01
`define MARGIN_HIGH         2'b10

// Fault handling codes while margining
`define FAULT_IGNORE        2'b01
`define FAULT_ACTIVE        2'b10

// Timing: initialisation interval
`define INIT_TIME_US        100
`define CLK_MHZ             100
`define INIT_CYCLES         (`INIT_TIME_US * `CLK_MHZ)

`endif

// ===== onoff_pkg.sv
// Types shared by the on/off control block and its channel state holder.
// Assumes the map header is on the include path.
package onoff_pkg;

	typedef enum logic [1:0] {
		CH_OFF,
		CH_TON_DELAY,
		CH_ON,
		CH_TOFF_DELAY
	} ch_state_t;

	typedef enum logic [1:0] {
		MG_NOMINAL,
		MG_LOW,
		MG_HIGH
	} margin_t;

endpackage

// ===== onoff_channel_regs.sv
// Per-channel register store: operation command, gating configuration
// and manufacturer configuration word, two pages each.
// Assumes a single write strobe from the serial command decoder.
`timescale 1ns/1ps
`include "onoff_map.svh"

module onoff_channel_regs
	import onoff_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_wr,
	input  wire logic [7:0]  i_cmd,
	input  wire logic [7:0]  i_page,
	input  wire logic [15:0] i_wdata,
	input  wire logic [7:0]  i_rd_cmd,
	input  wire logic        i_rd_page,
	output logic      [15:0] o_rdata,
	output logic      [15:0] o_op,
	output logic      [15:0] o_cfg,
	output logic      [31:0] o_mfr
);

	typedef struct packed {
		logic [1:0][7:0]  op;
		logic [1:0][7:0]  cfg;
		logic [1:0][15:0] mfr;
		logic [15:0]      rdata;
	} regs_t;

	regs_t s_q;
	regs_t s_d;

	always_comb
	begin
		s_d = s_q;
		for (int ch = 0; ch < 2; ch++)
		begin
			if (i_wr && (i_page == `PAGE_GLOBAL || i_page == 8'(ch)))
			begin
				if (i_cmd == `CMD_OPERATION)
					s_d.op[ch] = i_wdata[7:0] & `OP_WR_MASK;
				if (i_cmd == `CMD_ONOFF_CONFIG)
					s_d.cfg[ch] = (i_wdata[7:0] & `CFG_WR_MASK) | `CFG_RD_ONE;
				if (i_cmd == `CMD_MFR_CONFIG)
					s_d.mfr[ch] = i_wdata & `MFR_RSVD_MASK;
			end
		end
		case (i_rd_cmd)
			`CMD_OPERATION:    s_d.rdata = {8'h00, s_q.op[i_rd_page]};
			`CMD_ONOFF_CONFIG: s_d.rdata = {8'h00, s_q.cfg[i_rd_page]};
			`CMD_MFR_CONFIG:   s_d.rdata = s_q.mfr[i_rd_page];
			default:           s_d.rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			s_q.op    <= {2{`RST_OPERATION}};
			s_q.cfg   <= {2{`RST_ONOFF_CONFIG}};
			s_q.mfr   <= {2{`RST_MFR_CONFIG}};
			s_q.rdata <= 16'h0000;
		end
		else
			s_q <= s_d;
	end

	assign o_rdata = s_q.rdata;
	assign o_op    = s_q.op;
	assign o_cfg   = s_q.cfg;
	assign o_mfr   = s_q.mfr;

endmodule

// ===== onoff_control.sv
// Two-channel on/off and margin control: gating of start-up by control
// pins and bus commands, turn-on/off delays and margin selection.
// Assumes a decoded serial command port and asynchronous control pins.
`timescale 1ns/1ps
`include "onoff_map.svh"

module onoff_control
	import onoff_pkg::*;
#(
	parameter int INIT_CYCLES = `INIT_CYCLES
)
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_wr,
	input  wire logic [7:0]  i_cmd,
	input  wire logic [7:0]  i_page,
	input  wire logic [15:0] i_wdata,
	input  wire logic [7:0]  i_rd_cmd,
	input  wire logic        i_rd_page,
	output logic      [15:0] o_rdata,
	input  wire logic [1:0]  i_control_pin,
	input  wire logic        i_input_voltage_sense,
	input  wire logic [15:0] i_ton_delay,
	input  wire logic [15:0] i_toff_delay,
	output logic      [1:0]  o_channel_on,
	output logic      [1:0]  o_fast_off,
	output logic      [3:0]  o_margin,
	output logic      [1:0]  o_faults_ignored,
	output logic      [1:0]  o_uv_detect_en,
	output logic      [1:0]  o_cascade_on,
	output logic      [3:0]  o_state
);

	// ----------------------------------------------------------------
	// Register store
	// ----------------------------------------------------------------
	logic [15:0] op_w;
	logic [15:0] cfg_w;
	logic [31:0] mfr_w;

	onoff_channel_regs u_regs (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_wr      (i_wr),
		.i_cmd     (i_cmd),
		.i_page    (i_page),
		.i_wdata   (i_wdata),
		.i_rd_cmd  (i_rd_cmd),
		.i_rd_page (i_rd_page),
		.o_rdata   (o_rdata),
		.o_op      (op_w),
		.o_cfg     (cfg_w),
		.o_mfr     (mfr_w)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0][2:0]  pin_sync;
		logic [2:0]       vin_sync;
		logic [1:0]       pin_lvl;
		logic             vin_ok;
		logic [13:0]      init_cnt;
		logic             init_done;
		ch_state_t [1:0]  st;
		logic [1:0][15:0] dly;
		logic [1:0]       fast;
		logic [1:0]       ignore_f;
		logic [1:0][1:0]  margin;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic [1:0] en_w;
	logic [1:0] pin_off_w;

	// ----------------------------------------------------------------
	// Gating condition per channel
	// ----------------------------------------------------------------
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_gate
		logic [7:0] op;
		logic [7:0] cfg;
		logic       bus_on;
		logic       pin_ok;
		assign op  = op_w[ch*8 +: 8];
		assign cfg = cfg_w[ch*8 +: 8];
		assign bus_on = (op[`OP_CTRL_HI:`OP_CTRL_LO] == `CTRL_SEQ_ON);
		assign pin_ok = s_q.pin_lvl[ch];
		always_comb
		begin
			if (!cfg[`CFG_CONTROLLED_ON])
				en_w[ch] = 1'b1;
			else if (!cfg[`CFG_USE_BUS] && !cfg[`CFG_USE_PIN])
				en_w[ch] = 1'b0;
			else
				en_w[ch] = (!cfg[`CFG_USE_BUS] || bus_on)
					&& (!cfg[`CFG_USE_PIN] || pin_ok);
		end
		assign pin_off_w[ch] = cfg[`CFG_CONTROLLED_ON]
			&& cfg[`CFG_USE_PIN] && !pin_ok;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		// Three stages; a change counts when stages two and three agree
		for (int ch = 0; ch < 2; ch++)
		begin
			s_d.pin_sync[ch] = {s_q.pin_sync[ch][1:0], i_control_pin[ch]};
			if (s_q.pin_sync[ch][2] == s_q.pin_sync[ch][1])
				s_d.pin_lvl[ch] = s_q.pin_sync[ch][2];
		end
		s_d.vin_sync = {s_q.vin_sync[1:0], i_input_voltage_sense};
		if (s_q.vin_sync[2] == s_q.vin_sync[1])
			s_d.vin_ok = s_q.vin_sync[2];

		if (!s_q.init_done)
		begin
			if (s_q.init_cnt == 14'(INIT_CYCLES - 1))
				s_d.init_done = 1'b1;
			else
				s_d.init_cnt = s_q.init_cnt + 14'd1;
		end

		for (int ch = 0; ch < 2; ch++)
		begin
			logic [7:0] op;
			logic [7:0] cfg;
			logic       bus_ctl;
			logic       start_ok;
			logic       off_now;
			op       = op_w[ch*8 +: 8];
			cfg      = cfg_w[ch*8 +: 8];
			bus_ctl  = cfg[`CFG_CONTROLLED_ON] && cfg[`CFG_USE_BUS];
			start_ok = s_q.init_done && s_q.vin_ok && en_w[ch];
			off_now  = bus_ctl
				&& op[`OP_CTRL_HI:`OP_CTRL_LO] == `CTRL_OFF_NOW;

			case (op[`OP_MARGIN_HI:`OP_MARGIN_LO])
				`MARGIN_LOW:  s_d.margin[ch] = 2'(MG_LOW);
				`MARGIN_HIGH: s_d.margin[ch] = 2'(MG_HIGH);
				default:      s_d.margin[ch] = 2'(MG_NOMINAL);
			endcase
			s_d.ignore_f[ch] = (op[`OP_MARGIN_HI:`OP_MARGIN_LO]
				!= `MARGIN_NOMINAL)
				&& op[`OP_FAULT_HI:`OP_FAULT_LO] == `FAULT_IGNORE;

			case (s_q.st[ch])
				CH_OFF:
				begin
					s_d.fast[ch] = 1'b0;
					if (start_ok)
					begin
						s_d.st[ch]  = CH_TON_DELAY;
						s_d.dly[ch] = i_ton_delay;
					end
				end
				CH_TON_DELAY:
				begin
					if (!en_w[ch] || off_now)
						s_d.st[ch] = CH_OFF;
					else if (s_q.dly[ch] == 16'h0000)
						s_d.st[ch] = CH_ON;
					else
						s_d.dly[ch] = s_q.dly[ch] - 16'd1;
				end
				CH_ON:
				begin
					if (off_now)
						s_d.st[ch] = CH_OFF;
					else if (pin_off_w[ch] && cfg[`CFG_FAST_OFF])
					begin
						s_d.st[ch]   = CH_OFF;
						s_d.fast[ch] = 1'b1;
					end
					else if (!en_w[ch])
					begin
						s_d.st[ch]  = CH_TOFF_DELAY;
						s_d.dly[ch] = i_toff_delay;
					end
				end
				CH_TOFF_DELAY:
				begin
					if (off_now)
						s_d.st[ch] = CH_OFF;
					else if (pin_off_w[ch] && cfg[`CFG_FAST_OFF])
					begin
						s_d.st[ch]   = CH_OFF;
						s_d.fast[ch] = 1'b1;
					end
					else if (s_q.dly[ch] == 16'h0000)
						s_d.st[ch] = CH_OFF;
					else
						s_d.dly[ch] = s_q.dly[ch] - 16'd1;
				end
				default:
					s_d.st[ch] = CH_OFF;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			s_q <= '0;
			s_q.st <= {CH_OFF, CH_OFF};
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_out
		assign o_channel_on[ch] = (s_q.st[ch] == CH_ON)
			|| (s_q.st[ch] == CH_TOFF_DELAY);
		assign o_fast_off[ch]       = s_q.fast[ch];
		assign o_margin[ch*2 +: 2]  = s_q.margin[ch];
		assign o_faults_ignored[ch] = s_q.ignore_f[ch];
		assign o_uv_detect_en[ch] = !(mfr_w[ch*16 + `MFR_TRACK_EN]
			&& s_q.st[ch] == CH_TOFF_DELAY);
		assign o_cascade_on[ch]  = mfr_w[ch*16 + `MFR_CASCADE_ON];
		assign o_state[ch*2 +: 2] = s_q.st[ch];
	end

endmodule

// ===== onoff_control_monitor.sv
// Port checker for the on/off control block.
// Assumes it is bound to every onoff_control instance.
`timescale 1ns/1ps
module onoff_control_monitor (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_wr,
	input wire logic [7:0]  i_cmd,
	input wire logic [7:0]  i_page,
	input wire logic [15:0] i_wdata,
	input wire logic [7:0]  i_rd_cmd,
	input wire logic        i_input_voltage_sense,
	input wire logic [15:0] o_rdata,
	input wire logic [1:0]  o_fast_off,
	input wire logic [3:0]  o_margin,
	input wire logic [1:0]  o_faults_ignored,
	input wire logic [1:0]  o_uv_detect_en,
	input wire logic [3:0]  o_state
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence quiet3;
		!i_wr [*3];
	endsequence
	sequence vin_low6;
		!i_input_voltage_sense [*6];
	endsequence
	// Reserved margin code left out: the block drives the nominal margin output for it
	sequence op_wr(logic [7:0] pg);
		i_wr && i_cmd == 8'h01 && i_page == pg && i_wdata[5:4] != 2'b11;
	endsequence
	property p_margin(logic [7:0] pg);
		logic [1:0] m;
		(op_wr(pg), m = i_wdata[5:4]) ##1 quiet3 |->
			o_margin[1:0] == m && (pg != 8'hFF || o_margin[3:2] == m);
	endproperty
	property p_fault;
		logic f;
		(op_wr(8'h00), f = i_wdata[5:4] != 0 && i_wdata[3:2] == 2'b01)
			##1 quiet3 |-> o_faults_ignored[0] == f;
	endproperty
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_MARGIN: assert property (p_margin(8'h00))
		else $error("margin output differs from field");
	AST_GLOBAL: assert property (p_margin(8'hFF))
		else $error("global page write missed a channel");
	AST_FAULT: assert property (p_fault)
		else $error("fault ignore output wrong");
	AST_CFG_FIXED: assert property (i_rd_cmd == 8'h02 |=>
		o_rdata[7:5] == 3'b000 && o_rdata[1])
		else $error("gating config fixed bits wrong");
	AST_VIN_HOLD: assert property (vin_low6 ##0 o_state[1:0] == 2'b00
		|=> o_state[1:0] == 2'b00)
		else $error("start without input voltage");
	AST_NO_SKIP: assert property (o_state[1:0] == 2'b00 |=>
		o_state[1:0] inside {2'b00, 2'b01})
		else $error("off state skipped turn-on delay");
	AST_FAST_OFF: assert property ($rose(o_fast_off[0]) |->
		o_state[1:0] == 2'b00
		&& $past(o_state[1:0]) inside {2'b10, 2'b11})
		else $error("fast off did not go straight off");
	AST_UV_MASK: assert property (!o_uv_detect_en[0] |->
		o_state[1:0] == 2'b11 || $past(o_state[1:0]) == 2'b11)
		else $error("uv detection masked outside turn-off delay");
endmodule

bind onoff_control onoff_control_monitor onoff_control_monitor_i (
	.i_clk, .i_rst, .i_wr, .i_cmd, .i_page, .i_wdata, .i_rd_cmd,
	.i_input_voltage_sense, .o_rdata, .o_fast_off, .o_margin,
	.o_faults_ignored, .o_uv_detect_en, .o_state
);

// ===== onoff_pin_driver.sv
// External control pin drivers, one request level per channel.
// Assumes the bench sets the requested level.
`timescale 1ns/1ps
module onoff_pin_driver #(
	parameter int OFF_MIN = 8
)
(
	input  wire logic       i_clk,
	input  wire logic [1:0] i_req,
	output logic      [1:0] o_pin
);
	int off_cnt [2] = '{0, 0};
	initial o_pin = 2'h0;
	always @(posedge i_clk)
	begin
		for (int c = 0; c < 2; c++)
		begin
			if (o_pin[c])
				off_cnt[c] <= 0;
			else if (off_cnt[c] < OFF_MIN)
				off_cnt[c] <= off_cnt[c] + 1;
			if (o_pin[c] || off_cnt[c] >= OFF_MIN)
				o_pin[c] <= i_req[c];
		end
	end
endmodule

// ===== tb.sv
// Self-checking bench for the on/off control block.
// Assumes the pin driver and the bound checker are compiled first.
`timescale 1ns/1ps
module tb;
	localparam int INIT = 20;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_wr = 1'b0;
	logic        i_rd_page = 1'b0;
	logic        i_input_voltage_sense = 1'b1;
	logic [7:0]  i_cmd = 8'h00;
	logic [7:0]  i_page = 8'h00;
	logic [7:0]  i_rd_cmd = 8'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic [15:0] i_ton_delay = 16'h0003;
	logic [15:0] i_toff_delay = 16'h0014;
	logic [1:0]  pin_req = 2'h0;
	logic [1:0]  i_control_pin, o_channel_on, o_fast_off, o_cascade_on;
	logic [1:0]  o_faults_ignored, o_uv_detect_en;
	logic [3:0]  o_margin, o_state;
	logic [15:0] o_rdata, d, r [2];
	logic [7:0]  p, opv [2];
	logic [2:0]  e;
	logic        seen, uvl, fo;
	int          n_errors = 0;
	int          n_compared = 0;
	int          seed = 32'h4D79;
	int          k;
	logic [7:0]  cmds [4] = '{8'h01, 8'h02, 8'hD0, 8'h55};
	logic [15:0] rsts [4] = '{16'h0000, 16'h0012, 16'h0080, 16'h0000};
	logic [15:0] msks [3] = '{16'h00FC, 16'h001F, 16'hFDFF};
	logic [7:0]  gcfg [5] = '{8'h02, 8'h10, 8'h1A, 8'h16, 8'h1E};
	logic [7:0]  scfg [4] = '{8'h1A, 8'h1A, 8'h16, 8'h17};
	logic [7:0]  sop [4] = '{8'h40, 8'h00, 8'h80, 8'h80};
	logic [3:0]  spin = 4'h3;
	logic [3:0]  stoff = 4'h5;

	onoff_control #(.INIT_CYCLES(INIT)) onoff_control_i (
		.i_clk, .i_rst, .i_wr, .i_cmd, .i_page, .i_wdata, .i_rd_cmd,
		.i_rd_page, .o_rdata, .i_control_pin, .i_input_voltage_sense,
		.i_ton_delay, .i_toff_delay, .o_channel_on, .o_fast_off,
		.o_margin, .o_faults_ignored, .o_uv_detect_en, .o_cascade_on,
		.o_state
	);
	onoff_pin_driver onoff_pin_driver_i (
		.i_clk, .i_req(pin_req), .o_pin(i_control_pin)
	);
	// ----------------------------------------
	// Tasks and expectations
	// ----------------------------------------
	task automatic chk(string what, logic [15:0] x, logic [15:0] got);
		n_compared++;
		if (got !== x)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, x, got);
		end
	endtask
	task automatic wr(logic [7:0] c, logic [7:0] pg, logic [15:0] v);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_cmd <= c;
		i_page <= pg;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] c, logic pg, output logic [15:0] v);
		@(posedge i_clk);
		i_rd_cmd <= c;
		i_rd_page <= pg;
		repeat (2) @(posedge i_clk);
		#1 v = o_rdata;
	endtask
	task automatic do_reset();
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
	endtask
	task automatic wait_st(logic [1:0] s, int lim, output int n);
		#1 n = 0;
		while (o_state[1:0] !== s && n < lim)
		begin
			@(posedge i_clk);
			#1 n++;
		end
	endtask
	task automatic start(logic [7:0] cf, logic pin, logic [7:0] op);
		do_reset();
		pin_req <= {pin, pin};
		i_ton_delay <= 16'({$random(seed)} % 8);
		wr(8'h02, 8'hFF, {8'h00, cf});
		wr(8'h01, 8'hFF, {8'h00, op});
		repeat (INIT + 60) @(posedge i_clk);
		#1;
	endtask
	function automatic logic exp_on(logic [7:0] cf, logic pin,
		logic [7:0] op);
		return !cf[4] || (cf[3:2] != 2'b00 && (!cf[3] || op[7:6] == 2'b10)
			&& (!cf[2] || pin));
	endfunction
	task automatic complete_run();
		$display("Compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial
	begin
		forever #5 i_clk = ~i_clk;
	end
	initial
	begin
		repeat (30000) @(posedge i_clk);
		$display("Error watchdog expired");
		n_errors++;
		complete_run();
	end
	initial
	begin
		do_reset();
		for (int i = 0; i < 8; i++)
		begin
			rd(cmds[i % 4], i[2], d);
			chk("reset value", rsts[i % 4], d);
		end
		for (int i = 0; i < 6; i++)
		begin
			wr(cmds[i / 2], 8'hFF, 16'hFFFF);
			rd(cmds[i / 2], i[0], d);
			chk("masked value", msks[i / 2], d);
		end
		for (int i = 0; i < 2; i++)
		begin
			r[i] = 16'($random(seed));
			wr(8'hD0, 8'(i), r[i]);
		end
		for (int i = 0; i < 2; i++)
		begin
			rd(8'hD0, i[0], d);
			chk("mfr word", r[i] & 16'hFDFF, d);
		end
		chk("cascade", 16'({r[1][14], r[0][14]}), 16'(o_cascade_on));
		$display("register tests done");
		for (int i = 0; i < 8; i++)
		begin
			p = (i == 0 || ($random(seed) & 1)) ? 8'hFF : 8'(i & 1);
			d = {8'h00, 2'({$random(seed)} % 3), 2'({$random(seed)} % 3),
				2'h1 + 2'({$random(seed)} % 2), 2'h0};
			wr(8'h01, p, d);
			if (p == 8'hFF)
				opv = '{d[7:0], d[7:0]};
			else
				opv[p[0]] = d[7:0];
			repeat (3) @(posedge i_clk);
			#1;
			for (int c = 0; c < 2; c++)
			begin
				e = {opv[c][5:4] != 2'b00 && opv[c][3:2] == 2'b01, opv[c][5:4]};
				chk("margin", 16'(e[1:0]), 16'(o_margin[2*c+:2]));
				chk("faults ignored", 16'(e[2]), 16'(o_faults_ignored[c]));
			end
		end
		$display("margin tests done");
		do_reset();
		wr(8'h02, 8'hFF, 16'h0002);
		wait_st(2'h1, 200, k);
		chk("init wait", 16'h0001, 16'(k + 3 >= INIT));
		wait_st(2'h2, 100, k);
		chk("turn-on delay", i_ton_delay + 16'h0001, 16'(k));
		@(posedge i_clk) i_input_voltage_sense <= 1'b0;
		start(8'h02, 1'b0, 8'h00);
		chk("input voltage low", 16'h0000, 16'(o_state));
		@(posedge i_clk) i_input_voltage_sense <= 1'b1;
		wait_st(2'h2, 100, k);
		chk("input voltage high", 16'h0002, 16'(o_state[1:0]));
		$display("start-up tests done");
		for (int i = 0; i < 20; i++)
		begin
			start(gcfg[i / 4], i[0], i[1] ? 8'h80 : 8'h40);
			e = exp_on(gcfg[i / 4], i[0], i[1] ? 8'h80 : 8'h40) ? 3'h2 : 3'h0;
			chk("gated state", 16'({e[1:0], e[1:0]}), 16'(o_state));
			chk("channel on", 16'({e[1], e[1]}), 16'(o_channel_on));
		end
		$display("gating tests done");
		for (int i = 0; i < 4; i++)
		begin
			start(scfg[i], 1'b1, 8'h80);
			wr(8'hD0, 8'hFF, 16'h8000);
			pin_req <= {2{spin[i]}};
			wr(8'h01, 8'hFF, {8'h00, sop[i]});
			seen = 1'b0;
			uvl = 1'b0;
			fo = 1'b0;
			repeat (40)
			begin
				@(posedge i_clk);
				#1 seen |= o_state[1:0] == 2'h3;
				uvl |= o_uv_detect_en[0] === 1'b0;
				fo |= o_fast_off[0] === 1'b1;
			end
			chk("turn-off delay", 16'(stoff[i]), 16'(seen));
			chk("uv masked", 16'(stoff[i]), 16'(uvl));
			chk("fast off", 16'(i == 3), 16'(fo));
			chk("off state", 16'h0000, 16'(o_state));
		end
		$display("turn-off tests done");
		complete_run();
	end
endmodule
